// ==== rtl/wpc_frame_if.sv ====
// frame hand-off between the serial shifter and the command decoder
`timescale 1ns/100ps
interface wpc_frame_if;
    logic                done;
    wpc_pkg::wpc_frame_t word;
    wpc_pkg::wpc_frame_t reply;
    logic                serial_out;

    modport shifter (output done, output word, output serial_out, input reply);
    modport decoder (input done, input word, input serial_out, output reply);
endinterface

// ==== rtl/wpc_map.svh ====
// constants for the wiper otp command block: frame layout, codes, fields, timing
`ifndef WPC_MAP_SVH
`define WPC_MAP_SVH

`define WPC_FRAME_BITS    16
`define WPC_CMD_MSB       13
`define WPC_CMD_LSB       10
`define WPC_DATA_MSB      9
`define WPC_ADDR_MSB      4
`define WPC_SHDN_BIT      0
`define WPC_LAST_BIT      4'hF

`define WPC_CMD_NOP       4'h0
`define WPC_CMD_WR_WIPER  4'h1
`define WPC_CMD_RD_WIPER  4'h2
`define WPC_CMD_STORE     4'h3
`define WPC_CMD_RELOAD    4'h4
`define WPC_CMD_RD_OTP    4'h5
`define WPC_CMD_WR_CTRL   4'h6
`define WPC_CMD_RD_CTRL   4'h7
`define WPC_CMD_SHDN      4'h8

`define WPC_CTRL_PGM_EN   0
`define WPC_CTRL_UNLOCK   1
`define WPC_CTRL_CAL_SEL  2
`define WPC_CTRL_PGM_OK   3
`define WPC_CTRL_WR_MSB   2
`define WPC_CTRL_RESET    4'h0

`define WPC_MIDSCALE      10'h200
`define WPC_SLOT_COUNT    5'h14
`define WPC_ADDR_USE_LO   5'h14
`define WPC_ADDR_USE_HI   5'h15
`define WPC_USE_HALF      5'h0A

`define WPC_CLK_KHZ       20000
`define WPC_STORE_TIME_MS 6

`endif

// ==== rtl/wpc_pkg.sv ====
// types shared by the wiper otp command block
package wpc_pkg;
    typedef logic [9:0]  wpc_word_t;
    typedef logic [15:0] wpc_frame_t;
    typedef enum logic [0:0] {WPC_IDLE, WPC_STORING} wpc_phase_t;

    typedef struct packed {
        logic [3:0] ff1;
        logic [3:0] ff2;
    } wpc_sync_state_t;

    typedef struct packed {
        logic       sclk_d;
        logic       sync_b_d;
        logic [3:0] bit_cnt;
        logic       whole;
        wpc_frame_t in_sh;
        wpc_frame_t out_sh;
        logic       serial_out;
        logic       done;
        wpc_frame_t word;
    } wpc_shift_state_t;

    typedef struct packed {
        wpc_phase_t       phase;
        logic [16:0]      wait_cnt;
        logic [3:0]       ctrl;
        wpc_word_t        wiper;
        logic             shdn;
        logic [4:0]       used;
        logic [19:0][9:0] slots;
        wpc_frame_t       reply;
        logic             rst_pin_d;
    } wpc_top_state_t;
endpackage

// ==== rtl/wpc_shifter.sv ====
// serial frame shifter: samples data on clock fall, drives output on clock rise
`timescale 1ns/100ps
`include "wpc_map.svh"
module wpc_shifter (
    input  wire logic    clk_in,
    input  wire logic    rst_b_in,
    input  wire logic    clk_en_in,
    input  wire logic    sclk_in,
    input  wire logic    sync_b_in,
    input  wire logic    din_in,
    wpc_frame_if.shifter fr
);
    wpc_pkg::wpc_shift_state_t st_reg;
    wpc_pkg::wpc_shift_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en_in) begin
            // done pulse is state too, so it freezes with the enable
            st_next.done     = 1'b0;
            st_next.sclk_d   = sclk_in;
            st_next.sync_b_d = sync_b_in;
            if (st_reg.sync_b_d && !sync_b_in) begin
                st_next.out_sh  = fr.reply;
                st_next.bit_cnt = 4'h0;
                st_next.whole   = 1'b0;
            end else if (!sync_b_in) begin
                if (!st_reg.sclk_d && sclk_in) begin
                    st_next.serial_out    = st_reg.out_sh[`WPC_FRAME_BITS-1]; // RULE23
                    st_next.out_sh = {st_reg.out_sh[`WPC_FRAME_BITS-2:0], 1'b0};
                end
                if (st_reg.sclk_d && !sclk_in) begin
                    st_next.in_sh   = {st_reg.in_sh[`WPC_FRAME_BITS-2:0], din_in}; // RULE21
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    if (st_reg.bit_cnt == `WPC_LAST_BIT) begin
                        st_next.whole = 1'b1;
                    end
                end
            end else if (!st_reg.sync_b_d) begin
                // a frame counts only on a whole multiple of 16 bits
                st_next.done = st_reg.whole && (st_reg.bit_cnt == 4'h0); // RULE21
                st_next.word = st_reg.in_sh;
                st_next.serial_out  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= '{sclk_d: 1'b1, sync_b_d: 1'b1, bit_cnt: 4'h0, whole: 1'b0,
                        in_sh: 16'h0000, out_sh: 16'h0000, serial_out: 1'b1, done: 1'b0,
                        word: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign fr.done = st_reg.done;
    assign fr.word = st_reg.word;
    assign fr.serial_out  = st_reg.serial_out;
endmodule

// ==== rtl/wpc_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module wpc_sync (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       clk_en_in,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);
    wpc_pkg::wpc_sync_state_t st_reg;
    wpc_pkg::wpc_sync_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en_in) begin
            st_next.ff1 = async_in;
            st_next.ff2 = st_reg.ff1;
        end
    end

    // reset level of all pins is high: frame select, clock, data, reset pin
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= '{ff1: 4'hF, ff2: 4'hF};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.ff2;
endmodule

// ==== rtl/wpc_top.sv ====
// command and control core of a serially programmed potentiometer with 20-slot otp
// Notes on behaviour
// RULE1 - after power-up wiper and otp writes are refused until control bits set
// RULE2 - with unlock bit 0 wiper writes ignored; only reload or reset pin reload it
// RULE3 - host sets unlock bit with control write, code 6, before wiper writes
// RULE4 - program enable resets 0; store refused while it is 0
// RULE5 - control register occupies data bits 3..0; bits 9..4 ignored on write
// RULE6 - calibration select 0 is resistor performance mode, 1 is normal mode
// RULE7 - program-success bit is 1 after a good store, 0 by default
// RULE8 - while locked wiper holds last stored value, or midscale if none stored
// RULE9 - code 1 with unlock set loads data field into wiper register
// RULE10 - code 3 copies wiper into next otp slot within 6 ms, ready shows done
// RULE11 - code 5 takes five low data bits as slot; next frame returns it
// RULE12 - addresses 0x00..0x13 return programmed values in programming order
// RULE13 - addresses 0x14, 0x15 give thermometer usage; ones minus one is last slot
// RULE14 - with no slot programmed both usage words are all zero
// RULE15 - code 8 with bit 0 set enters shutdown: A open, wiper to B
// RULE16 - shutdown keeps wiper register and all commands still work
// RULE17 - code 8 with bit 0 clear leaves shutdown
// RULE18 - after word 0x1C00 the next reply holds control register in low four bits
// RULE19 - after word 0x0800 the next reply holds wiper register in low ten bits
// RULE20 - word 0x1803 sets unlock and program enable together
// RULE21 - frames are 16 bits msb first: 00, 4-bit code, 10 data; decoded on select rise
// RULE22 - reset pin rising edge reloads wiper from last slot, control to defaults; code drops an edge that arrives while storing
// RULE23 - serial output changes on serial clock rising edges
// RULE24 - without a read command the reply echoes the previous input word
// RULE25 - frames ignored while storing; store refused when all 20 slots used
`timescale 1ns/100ps
`include "wpc_map.svh"
module wpc_top #(
    parameter int unsigned STORE_CYCLES = `WPC_STORE_TIME_MS * `WPC_CLK_KHZ
) (
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_B_IN,
    input  wire logic       CLK_EN_IN,
    input  wire logic       SYNC_B_IN,
    input  wire logic       SCLK_IN,
    input  wire logic       DIN_IN,
    input  wire logic       HW_RESET_B_IN,
    output logic            SDO_OUT,
    output logic            SDO_OE_B_OUT,
    output logic            RDY_OUT,
    output logic      [9:0] WIPER_OUT,
    output logic            SHUTDOWN_OUT,
    output logic            RES_PERF_MODE_OUT,
    output logic      [3:0] CONTROL_OUT,
    output logic      [4:0] SLOTS_USED_OUT
);
    wpc_pkg::wpc_top_state_t st_reg;
    wpc_pkg::wpc_top_state_t st_next;

    logic [3:0] pins_sync;
    wpc_frame_if fr ();

    // frame select, clock, data and reset pin all come from outside this clock
    wpc_sync u_sync (
        .clk_in    (CLK_SYS_IN),
        .rst_b_in  (RST_B_IN),
        .clk_en_in (CLK_EN_IN),
        .async_in  ({HW_RESET_B_IN, DIN_IN, SCLK_IN, SYNC_B_IN}),
        .sync_out  (pins_sync)
    );

    wpc_shifter u_shift (
        .clk_in    (CLK_SYS_IN),
        .rst_b_in  (RST_B_IN),
        .clk_en_in (CLK_EN_IN),
        .sclk_in   (pins_sync[1]),
        .sync_b_in (pins_sync[0]),
        .din_in    (pins_sync[2]),
        .fr        (fr)
    );

    logic [3:0]          cmd;
    wpc_pkg::wpc_word_t  data;
    logic [4:0]          addr;
    wpc_pkg::wpc_word_t  stored_val;
    wpc_pkg::wpc_word_t  use_lo;
    wpc_pkg::wpc_word_t  use_hi;
    wpc_pkg::wpc_word_t  otp_read;
    logic                rst_pin_rise;
    logic                store_ok;

    assign cmd  = fr.word[`WPC_CMD_MSB:`WPC_CMD_LSB];
    assign data = fr.word[`WPC_DATA_MSB:0];
    assign addr = fr.word[`WPC_ADDR_MSB:0];
    assign rst_pin_rise = !st_reg.rst_pin_d && pins_sync[3];
    assign store_ok = st_reg.ctrl[`WPC_CTRL_PGM_EN] && (st_reg.used < `WPC_SLOT_COUNT);

    // value a reload restores: the newest slot, midscale on a blank part
    always_comb begin
        if (st_reg.used == 5'h00) begin
            stored_val = `WPC_MIDSCALE; // RULE8
        end else begin
            stored_val = st_reg.slots[st_reg.used - 5'h01]; // RULE22
        end
    end

    // thermometer usage words fill from bit 0 upward, low word first
    always_comb begin
        use_lo = 10'h000;
        use_hi = 10'h000;
        for (int i = 0; i < 10; i++) begin
            use_lo[i] = (st_reg.used > 5'(i)); // RULE13 RULE14
            use_hi[i] = (st_reg.used > 5'(i) + `WPC_USE_HALF); // RULE13 RULE14
        end
    end

    always_comb begin
        if (addr < `WPC_SLOT_COUNT) begin
            otp_read = st_reg.slots[addr]; // RULE12
        end else if (addr == `WPC_ADDR_USE_LO) begin
            otp_read = use_lo;
        end else if (addr == `WPC_ADDR_USE_HI) begin
            otp_read = use_hi;
        end else begin
            otp_read = 10'h000;
        end
    end

    always_comb begin
        st_next = st_reg;
        if (CLK_EN_IN) begin
            st_next.rst_pin_d = pins_sync[3];
            case (st_reg.phase)
                wpc_pkg::WPC_IDLE: begin
                    if (fr.done) begin
                        st_next.reply = fr.word; // RULE24
                        case (cmd)
                            `WPC_CMD_WR_WIPER: begin
                                if (st_reg.ctrl[`WPC_CTRL_UNLOCK]) begin
                                    st_next.wiper = data; // RULE1 RULE2 RULE9
                                end
                            end
                            `WPC_CMD_RD_WIPER: begin
                                st_next.reply = {6'h00, st_reg.wiper}; // RULE19
                            end
                            `WPC_CMD_STORE: begin
                                if (store_ok) begin
                                    st_next.phase    = wpc_pkg::WPC_STORING; // RULE10
                                    st_next.wait_cnt = 17'h00000;
                                end else begin
                                    // refused: not enabled or otp exhausted
                                    st_next.ctrl[`WPC_CTRL_PGM_OK] = 1'b0; // RULE1 RULE4 RULE25
                                end
                            end
                            `WPC_CMD_RELOAD: begin
                                st_next.wiper = stored_val; // RULE2
                            end
                            `WPC_CMD_RD_OTP: begin
                                st_next.reply = {6'h00, otp_read}; // RULE11
                            end
                            `WPC_CMD_WR_CTRL: begin
                                // success flag stays hardware-owned
                                st_next.ctrl[`WPC_CTRL_WR_MSB:0] =
                                    data[`WPC_CTRL_WR_MSB:0]; // RULE5 RULE20
                            end
                            `WPC_CMD_RD_CTRL: begin
                                st_next.reply = {12'h000, st_reg.ctrl}; // RULE18
                            end
                            `WPC_CMD_SHDN: begin
                                st_next.shdn = data[`WPC_SHDN_BIT]; // RULE15 RULE16 RULE17
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                wpc_pkg::WPC_STORING: begin
                    // frames arriving now are dropped, reply word keeps its value
                    if (st_reg.wait_cnt == 17'(STORE_CYCLES - 1)) begin
                        st_next.phase                  = wpc_pkg::WPC_IDLE;
                        st_next.slots[st_reg.used]     = st_reg.wiper; // RULE10 RULE12
                        st_next.used                   = st_reg.used + 5'h01;
                        st_next.ctrl[`WPC_CTRL_PGM_OK] = 1'b1; // RULE7
                    end else begin
                        st_next.wait_cnt = st_reg.wait_cnt + 17'h00001; // RULE25
                    end
                end
                default: begin
                    st_next.phase = wpc_pkg::WPC_IDLE;
                end
            endcase
            // pin reset wins over a command in the same cycle, but not over a store
            if (rst_pin_rise && st_reg.phase == wpc_pkg::WPC_IDLE) begin
                st_next.wiper = stored_val; // RULE22
                st_next.ctrl  = `WPC_CTRL_RESET; // RULE22
            end
        end
    end

    // otp contents start blank here; a real part keeps them across power cycles
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_reg.phase     <= wpc_pkg::WPC_IDLE;
            st_reg.wait_cnt  <= 17'h00000;
            st_reg.ctrl      <= `WPC_CTRL_RESET; // RULE1 RULE4 RULE6 RULE7
            st_reg.wiper     <= `WPC_MIDSCALE; // RULE8
            st_reg.shdn      <= 1'b0;
            st_reg.used      <= 5'h00;
            st_reg.slots     <= '0;
            st_reg.reply     <= 16'h0000;
            st_reg.rst_pin_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fr.reply = st_reg.reply;

    // open drain: only ever pulls low, enable low while pulling
    assign SDO_OUT           = 1'b0;
    assign SDO_OE_B_OUT      = fr.serial_out; // RULE23
    assign RDY_OUT           = (st_reg.phase == wpc_pkg::WPC_IDLE); // RULE10
    assign WIPER_OUT         = st_reg.wiper;
    assign SHUTDOWN_OUT      = st_reg.shdn; // RULE15
    assign RES_PERF_MODE_OUT = !st_reg.ctrl[`WPC_CTRL_CAL_SEL]; // RULE6
    assign CONTROL_OUT       = st_reg.ctrl;
    assign SLOTS_USED_OUT    = st_reg.used;
endmodule

// ==== test/wiper_otp_command_control_bench.sv ====
// self-checking bench for the wiper otp command block
`timescale 1ns/100ps
module wiper_otp_command_control_bench;
    localparam int unsigned STORE_CYCLES = 400;
    logic        CLK_SYS_IN, RST_B_IN, HW_RESET_B_IN, SYNC_B_IN, SCLK_IN, DIN_IN, CLK_EN_IN;
    logic        SDO_OUT, SDO_OE_B_OUT, RDY_OUT, SHUTDOWN_OUT, RES_PERF_MODE_OUT;
    logic [9:0]  WIPER_OUT;
    logic [3:0]  CONTROL_OUT;
    logic [4:0]  SLOTS_USED_OUT;
    logic [15:0] rep;
    int          n_errors, checked;

    wpc_top #(.STORE_CYCLES(STORE_CYCLES)) dut (.CLK_SYS_IN, .RST_B_IN, .CLK_EN_IN,
        .SYNC_B_IN, .SCLK_IN, .DIN_IN, .HW_RESET_B_IN, .SDO_OUT, .SDO_OE_B_OUT, .RDY_OUT,
        .WIPER_OUT, .SHUTDOWN_OUT, .RES_PERF_MODE_OUT, .CONTROL_OUT, .SLOTS_USED_OUT);
    wpc_host_model host (.clk_in(CLK_SYS_IN), .sdo_in(SDO_OUT), .sdo_oe_b_in(SDO_OE_B_OUT),
        .sync_b_out(SYNC_B_IN), .sclk_out(SCLK_IN), .din_out(DIN_IN));

    function automatic logic [15:0] stat();
        return {4'h0, RDY_OUT, SHUTDOWN_OUT, RES_PERF_MODE_OUT, SLOTS_USED_OUT, CONTROL_OUT};
    endfunction
    function automatic logic [15:0] slot_val(input int k);
        return {6'h00, 10'(k * 37 + 5)};
    endfunction

    task automatic print_verdict;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w);
        host.xfer(w, rep);
    endtask
    task automatic read_back(input logic [15:0] w, input logic [15:0] exp);
        host.xfer(w, rep);
        host.xfer(16'h0000, rep);
        chk(rep, exp);
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        while (RDY_OUT !== 1'b1 && k < 1000) begin
            @(negedge CLK_SYS_IN);
            k++;
        end
        if (k == 1000) begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic t_locked;
        chk(stat(), 16'h0A00);
        chk({6'h00, WIPER_OUT}, 16'h0200);
        read_back(16'h0500, 16'h0500);
        chk({6'h00, WIPER_OUT}, 16'h0200);
        send(16'h0C00);
        wait_ready();
        chk(stat(), 16'h0A00);
        read_back(16'h1414, 16'h0000);
        read_back(16'h1415, 16'h0000);
        send(16'h1000);
        chk({6'h00, WIPER_OUT}, 16'h0200);
    endtask
    task automatic t_control;
        send(16'h1BF7);
        chk(stat(), 16'h0807);
        read_back(16'h1C00, 16'h0007);
        send(16'h1803);
        chk(stat(), 16'h0A03);
        send(16'h0500);
        chk({6'h00, WIPER_OUT}, 16'h0100);
        read_back(16'h0800, 16'h0100);
    endtask
    task automatic t_store_all;
        for (int k = 0; k < 20; k++) begin
            send(16'h0400 | slot_val(k));
            send(16'h0C00);
            // second frame lands entirely inside the busy window
            if (k == 0) send(16'h07FF);
            wait_ready();
            chk(stat(), 16'h0A0B | 16'((k + 1) << 4));
            chk({6'h00, WIPER_OUT}, slot_val(k));
            if (k == 17) read_back(16'h1415, 16'h00FF);
        end
        send(16'h0C00);
        wait_ready();
        chk(stat(), 16'h0B43);
        host.xfer(16'h1400, rep);
        // unused address bits set high to prove they are ignored
        for (int k = 1; k <= 21; k++) begin
            host.xfer(16'h17E0 | 16'(k), rep);
            chk(rep, k <= 20 ? slot_val(k - 1) : 16'h03FF);
        end
        host.xfer(16'h0000, rep);
        chk(rep, 16'h03FF);
    endtask
    task automatic t_shutdown;
        send(16'h2001);
        chk(stat(), 16'h0F43);
        chk({6'h00, WIPER_OUT}, slot_val(19));
        send(16'h0555);
        chk({6'h00, WIPER_OUT}, 16'h0155);
        send(16'h2000);
        chk(stat(), 16'h0B43);
    endtask
    task automatic t_pin_reset;
        // a frame sent while the enable is low must leave no trace
        CLK_EN_IN = 1'b0;
        send(16'h0401);
        CLK_EN_IN = 1'b1;
        repeat (4) @(negedge CLK_SYS_IN);
        chk({6'h00, WIPER_OUT}, 16'h0155);
        HW_RESET_B_IN = 1'b0;
        repeat (4) @(negedge CLK_SYS_IN);
        HW_RESET_B_IN = 1'b1;
        repeat (8) @(negedge CLK_SYS_IN);
        chk(stat(), 16'h0B40);
        chk({6'h00, WIPER_OUT}, slot_val(19));
        send(16'h0433);
        chk({6'h00, WIPER_OUT}, slot_val(19));
    endtask

    initial begin
        CLK_SYS_IN = 1'b0;
        forever #25 CLK_SYS_IN = ~CLK_SYS_IN;
    end

    initial begin
        n_errors = 0;
        checked = 0;
        RST_B_IN = 1'b0;
        HW_RESET_B_IN = 1'b1;
        CLK_EN_IN = 1'b1;
        repeat (3) @(negedge CLK_SYS_IN);
        RST_B_IN = 1'b1;
        repeat (3) @(negedge CLK_SYS_IN);
        t_locked();
        t_control();
        t_store_all();
        t_shutdown();
        t_pin_reset();
        print_verdict();
    end
endmodule

bind wpc_top wpc_monitor #(.STORE_CYCLES(STORE_CYCLES)) mon (.CLK_SYS_IN, .RST_B_IN,
    .CLK_EN_IN, .SYNC_B_IN, .SCLK_IN, .DIN_IN, .HW_RESET_B_IN, .SDO_OUT, .SDO_OE_B_OUT,
    .RDY_OUT, .WIPER_OUT, .SHUTDOWN_OUT, .RES_PERF_MODE_OUT, .CONTROL_OUT, .SLOTS_USED_OUT);

// ==== test/wpc_host_model.sv ====
// serial host: sends 16-bit frames msb first and captures the reply
`timescale 1ns/100ps
module wpc_host_model (
    input  wire logic clk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_b_in,
    output logic      sync_b_out,
    output logic      sclk_out,
    output logic      din_out
);
    logic line;

    // open-drain line with pull-up
    assign line = sdo_oe_b_in ? 1'b1 : sdo_in;

    initial begin
        sync_b_out = 1'b1;
        sclk_out   = 1'b0;
        din_out    = 1'b0;
    end

    // link clock stands still low outside frames
    task automatic xfer(input logic [15:0] word, output logic [15:0] reply);
        sync_b_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int i = 15; i >= 0; i--) begin
            din_out = word[i];
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b1;
            repeat (4) @(negedge clk_in);
            reply[i] = line;
            sclk_out = 1'b0;
            repeat (2) @(negedge clk_in);
        end
        sync_b_out = 1'b1;
        // released data must not look like a held bit
        din_out = ~din_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// ==== test/wpc_monitor.sv ====
// port-level assertions for the wiper otp command block
`timescale 1ns/100ps
module wpc_monitor #(
    parameter int unsigned STORE_CYCLES = 120000
) (
    input wire logic       CLK_SYS_IN,
    input wire logic       RST_B_IN,
    input wire logic       CLK_EN_IN,
    input wire logic       SYNC_B_IN,
    input wire logic       SCLK_IN,
    input wire logic       DIN_IN,
    input wire logic       HW_RESET_B_IN,
    input wire logic       SDO_OUT,
    input wire logic       SDO_OE_B_OUT,
    input wire logic       RDY_OUT,
    input wire logic [9:0] WIPER_OUT,
    input wire logic       SHUTDOWN_OUT,
    input wire logic       RES_PERF_MODE_OUT,
    input wire logic [3:0] CONTROL_OUT,
    input wire logic [4:0] SLOTS_USED_OUT
);
    logic [16:0] low_cnt_reg;

    // counts busy cycles so the store length is checked exactly, not just bounded
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            low_cnt_reg <= 17'h00000;
        end else if (!RDY_OUT) begin
            low_cnt_reg <= low_cnt_reg + 17'h00001;
        end else begin
            low_cnt_reg <= 17'h00000;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);

    a_store_length: assert property (
        $rose(RDY_OUT) |-> 32'(low_cnt_reg) == STORE_CYCLES) else $error("store length wrong");
    a_store_bound: assert property (
        $fell(RDY_OUT) |-> ##[1:1000] RDY_OUT) else $error("store never ends");
    a_store_result: assert property (
        $rose(RDY_OUT) |-> SLOTS_USED_OUT == $past(SLOTS_USED_OUT) + 5'h01 && CONTROL_OUT[3])
        else $error("store result wrong");
    a_slots_on_store: assert property (
        $changed(SLOTS_USED_OUT) |-> $rose(RDY_OUT)) else $error("slot count moved");
    a_ok_on_store: assert property (
        $rose(CONTROL_OUT[3]) |-> $rose(RDY_OUT)) else $error("success bit without store");
    a_slots_limit: assert property (
        SLOTS_USED_OUT <= 5'h14) else $error("too many slots");
    a_perf_mode: assert property (
        RES_PERF_MODE_OUT == !CONTROL_OUT[2]) else $error("mode select wrong");
    a_store_freeze: assert property (
        !RDY_OUT && !$past(RDY_OUT) |-> $stable(WIPER_OUT) && $stable(SHUTDOWN_OUT))
        else $error("state changed while storing");
    a_shdn_keeps: assert property (
        $changed(SHUTDOWN_OUT) |-> $stable(WIPER_OUT)) else $error("shutdown moved wiper");
    a_sdo_idle: assert property (
        SYNC_B_IN [*6] |-> SDO_OE_B_OUT) else $error("data line held outside frame");
    a_sdo_edge: assert property (
        $changed(SDO_OE_B_OUT) && !SYNC_B_IN |-> $past(SCLK_IN, 2) || $past(SCLK_IN, 3))
        else $error("data line moved off clock rise");
endmodule
